// >>> enp_burst_match.sv
// counts consecutive consistent received bursts, ignoring the ack bit
`timescale 1ns/1ps
module enp_burst_match
  import enp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // restart and received codewords
  input wire logic restart,
  input wire logic cw_valid,
  input wire logic [15:0] cw,
  // one pulse when the page is settled, with the page
  output logic match,
  output logic [15:0] page
);
  logic [1:0] count;
  logic same;

  // the ack bit may flip between bursts without breaking the run
  assign same = ({page[15], page[13:0]} == {cw[15], cw[13:0]});

  // --------------------------------------------------------------
  // run counter, saturates after the pulse so it fires once per page
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count <= 2'h0;
      page <= 16'h0000;
      match <= 1'b0;
    end else begin
      match <= 1'b0;
      if (restart) begin
        count <= 2'h0;
      end else if (cw_valid) begin
        page <= cw;
        if (count != 2'h0 && same) begin
          if (count != ENP_MATCH_NEEDED) begin
            count <= count + 2'h1;
            match <= (count + 2'h1 == ENP_MATCH_NEEDED);
          end
        end else begin
          count <= 2'h1;
        end
      end
    end
  end
endmodule : enp_burst_match

// >>> enp_checker.sv
// concurrent checks on the next-page register bank ports
`timescale 1ns/1ps
module enp_checker
  import enp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // link lanes
  input wire logic [ENP_NPORT-1:0] lnk_restart,
  input wire logic [ENP_NPORT-1:0] lnk_base_sent,
  input wire logic [ENP_NPORT-1:0][15:0] lnk_base_cw,
  input wire logic [ENP_NPORT-1:0] lnk_page_sent,
  input wire logic [ENP_NPORT-1:0] lnk_rx_valid,
  input wire logic [ENP_NPORT-1:0][15:0] lnk_rx_cw,
  input wire logic [ENP_NPORT-1:0][15:0] lnk_tx_cw,
  input wire logic [ENP_NPORT-1:0] lnk_page_rx
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // --------------------------------------------
  // helper state, first lane only to stay small
  // --------------------------------------------
  wire tg = lnk_tx_cw[0][ENP_BIT_TOGGLE];
  wire ack = lnk_tx_cw[0][ENP_BIT_ACK];
  wire quiet = !(lnk_restart[0] || lnk_base_sent[0] || lnk_page_sent[0]);
  wire mapped = reg_addr inside {ENP_ADDR_IND_CTRL, ENP_ADDR_IND_OFFSET, ENP_ADDR_IND_DATA};
  logic based;
  logic [1:0] run_len;
  logic [15:0] prev_cw;
  // base codeword seen since the last restart
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      based <= 1'b0;
    else if (lnk_restart[0])
      based <= 1'b0;
    else if (lnk_base_sent[0])
      based <= 1'b1;
  end
  // run of like bursts, ack bit masked, saturating at three
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_len <= 2'h0;
      prev_cw <= 16'h0000;
    end else if (lnk_restart[0]) begin
      run_len <= 2'h0;
    end else if (lnk_rx_valid[0]) begin
      prev_cw <= lnk_rx_cw[0];
      if (run_len == 2'h0 || ((lnk_rx_cw[0] ^ prev_cw) & 16'hBFFF) != 16'h0000)
        run_len <= 2'h1;
      else if (run_len != 2'h3)
        run_len <= run_len + 2'h1;
    end
  end
  // toggle history and transmit word are two flop stages, so a lane event shows on the word two edges later
  toggle_seed_a: assert property (
    lnk_base_sent[0] && quiet == 1'b0 && !lnk_page_sent[0] && !lnk_restart[0]
    |=> ##1 tg == !$past(lnk_base_cw[0][ENP_BIT_TOGGLE], 2)) else $error("toggle not seeded from base");
  toggle_flip_a: assert property (
    based && lnk_page_sent[0] && !lnk_base_sent[0] && !lnk_restart[0] |=> ##1 tg != $past(tg, 2))
    else $error("toggle did not invert");
  toggle_hold_a: assert property (based && quiet && $past(quiet) |=> $stable(tg))
    else $error("toggle moved");
  ack_run_a: assert property ($rose(ack) |-> run_len == 2'h3) else $error("ack before three bursts");
  ack_clear_a: assert property (
    (lnk_page_sent[0] || lnk_restart[0]) && !lnk_rx_valid[0] && !$past(lnk_rx_valid[0]) |=> ##1 !ack)
    else $error("ack not cleared");
  ack_bit_a: assert property (lnk_page_rx[0] |-> ack) else $error("ack missing at bit 14");
  page_pulse_a: assert property (lnk_page_rx[0] |=> !lnk_page_rx[0]) else $error("page pulse long");
  page_base_a: assert property (lnk_page_rx[0] |-> based) else $error("page loaded before base");
  rd_hold_a: assert property (
    !reg_rd && !$past(reg_rd) |=> $stable(reg_rdata)) else $error("read byte moved");
  unmapped_rd_a: assert property (
    reg_rd && !mapped |-> ##2 reg_rdata == 8'h00) else $error("unmapped read not zero");
  cover property ($rose(ack));
  cover property (lnk_page_rx[0]);
  cover property (based && lnk_page_sent[0]);
endmodule : enp_checker

// >>> enp_eee_np_regs.sv
// per-port next-page register bank for energy-efficient ethernet negotiation
`timescale 1ns/1ps
module enp_eee_np_regs
  import enp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // byte register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // negotiation events, one lane per port, index 0 is port 3
  input wire logic [ENP_NPORT-1:0] lnk_restart,
  input wire logic [ENP_NPORT-1:0] lnk_base_sent,
  input wire logic [ENP_NPORT-1:0][15:0] lnk_base_cw,
  input wire logic [ENP_NPORT-1:0] lnk_page_sent,
  // received codewords
  input wire logic [ENP_NPORT-1:0] lnk_rx_valid,
  input wire logic [ENP_NPORT-1:0][15:0] lnk_rx_cw,
  // codeword to send and page-received pulse
  output logic [ENP_NPORT-1:0][15:0] lnk_tx_cw,
  output logic [ENP_NPORT-1:0] lnk_page_rx
);
  enp_ind_if ind ();
  logic [ENP_NPORT-1:0][7:0] port_byte;

  // --------------------------------------------------------------
  // indirect access decoder
  // --------------------------------------------------------------
  enp_indirect u_indirect (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .ind(ind)
  );

  // --------------------------------------------------------------
  // byte view of a port's registers
  // --------------------------------------------------------------
  // unlisted offsets read zero; the capability status stays all clear
  function automatic logic [7:0] pick_byte(input logic [7:0] off, input logic [15:0] tx_reg,
                                           input logic [15:0] lp_reg);
    logic [7:0] b;
    b = 8'h00;
    case (off)
      ENP_OFF_TX_HI: b = tx_reg[15:8];
      ENP_OFF_TX_LO: b = tx_reg[7:0];
      ENP_OFF_LP_HI: b = lp_reg[15:8];
      ENP_OFF_LP_LO: b = lp_reg[7:0];
      ENP_OFF_CAP_HI: b = ENP_CAP_STATUS[15:8];
      ENP_OFF_CAP_LO: b = ENP_CAP_STATUS[7:0];
      default: b = 8'h00;
    endcase
    return b;
  endfunction : pick_byte

  // --------------------------------------------------------------
  // per-port next-page engines
  // --------------------------------------------------------------
  for (genvar p = 0; p < ENP_NPORT; p++) begin : g_port
    logic more_pages_flag;
    logic message_page_flag;
    logic comply_ack;
    logic [10:0] code;
    logic prev_toggle;
    logic ack_flag;
    logic np_phase;
    logic [15:0] partner_next_page;
    logic [15:0] local_next_page_transmit;
    logic match;
    logic [15:0] match_page;
    logic wr_hi;
    logic wr_lo;

    // consistency detector on this port's receive stream
    enp_burst_match u_match (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .restart(lnk_restart[p]),
      .cw_valid(lnk_rx_valid[p]),
      .cw(lnk_rx_cw[p]),
      .match(match),
      .page(match_page)
    );

    // byte writes only land when this port is the selected one
    assign wr_hi = ind.wr && ind.port_hit[p] && (ind.offset == ENP_OFF_TX_HI);
    assign wr_lo = ind.wr && ind.port_hit[p] && (ind.offset == ENP_OFF_TX_LO);

    // software-visible transmit register; ack and toggle are status
    assign local_next_page_transmit = {more_pages_flag, ack_flag, message_page_flag, comply_ack,
                                       ~prev_toggle, code};

    // transmit page fields written by software
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        more_pages_flag <= ENP_MORE_RESET;
        message_page_flag <= ENP_MSG_RESET;
        comply_ack <= ENP_COMPLY_RESET;
        code <= ENP_CODE_RESET;
      end else begin
        if (wr_hi) begin
          more_pages_flag <= ind.wbyte[ENP_BIT_MORE-8];
          message_page_flag <= ind.wbyte[ENP_BIT_MSG-8];
          comply_ack <= ind.wbyte[ENP_BIT_COMPLY-8];
          code[10:8] <= ind.wbyte[ENP_CODE_MSB-8:0];
        end
        if (wr_lo) begin
          code[7:0] <= ind.wbyte;
        end
      end
    end

    // toggle history: base page seeds it, each page sent in the next-page phase advances it
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        prev_toggle <= 1'b0;
      end else if (lnk_base_sent[p]) begin
        prev_toggle <= lnk_base_cw[p][ENP_BIT_TOGGLE];
      end else if (lnk_page_sent[p] && np_phase) begin
        prev_toggle <= ~prev_toggle;
      end
    end

    // next-page phase opens once the base page has gone out
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        np_phase <= 1'b0;
      end else if (lnk_restart[p]) begin
        np_phase <= 1'b0;
      end else if (lnk_base_sent[p]) begin
        np_phase <= 1'b1;
      end
    end

    // acknowledge: a settled page sets it, and that set beats a clear
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        ack_flag <= 1'b0;
      end else if (match) begin
        ack_flag <= 1'b1;
      end else if (lnk_page_sent[p] || lnk_restart[p]) begin
        ack_flag <= 1'b0;
      end
    end

    // partner register only takes pages settled in the next-page phase
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        partner_next_page <= ENP_LP_RESET;
        lnk_page_rx[p] <= 1'b0;
      end else begin
        lnk_page_rx[p] <= match && np_phase;
        if (match && np_phase) begin
          partner_next_page <= match_page;
        end
      end
    end

    // outgoing codeword, registered so the line sees no glitches
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        lnk_tx_cw[p] <= 16'h0000;
      end else begin
        lnk_tx_cw[p] <= local_next_page_transmit;
        lnk_tx_cw[p][ENP_BIT_ACK] <= ack_flag || match;
      end
    end

    // read view for the indirect data register
    assign port_byte[p] = ind.port_hit[p] ?
      pick_byte(ind.offset, local_next_page_transmit, partner_next_page) : 8'h00;
  end

  // --------------------------------------------------------------
  // merge port read bytes; at most one port is selected at a time
  // --------------------------------------------------------------
  always_comb begin
    ind.rd_byte = 8'h00;
    for (int i = 0; i < ENP_NPORT; i++) begin
      ind.rd_byte = ind.rd_byte | port_byte[i];
    end
  end
endmodule : enp_eee_np_regs

// >>> enp_ind_if.sv
// carrier between the indirect access decoder and the port bank
`timescale 1ns/1ps
interface enp_ind_if;
  import enp_pkg::*;
  logic [ENP_NPORT-1:0] port_hit;
  logic [7:0] offset;
  logic wr;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  modport decoder (output port_hit, output offset, output wr, output wbyte, input rd_byte);
  modport bank (input port_hit, input offset, input wr, input wbyte, output rd_byte);
endinterface : enp_ind_if

// >>> enp_indirect.sv
// indirect control, offset and data byte access decoder
`timescale 1ns/1ps
module enp_indirect
  import enp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // toward the port bank
  enp_ind_if.decoder ind
);
  logic [7:0] ctrl;
  logic [7:0] offset;
  logic table_ok;

  // --------------------------------------------------------------
  // control and offset registers
  // --------------------------------------------------------------
  // plain byte stores; software sets them before touching data
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= ENP_CTRL_RESET;
      offset <= ENP_OFFSET_RESET;
    end else if (reg_wr) begin
      if (reg_addr == ENP_ADDR_IND_CTRL) begin
        ctrl <= reg_wdata;
      end
      if (reg_addr == ENP_ADDR_IND_OFFSET) begin
        offset <= reg_wdata;
      end
    end
  end

  // --------------------------------------------------------------
  // table and port decode
  // --------------------------------------------------------------
  // other tables or ports fall through: writes dropped, reads zero
  assign table_ok = (ctrl[ENP_TABLE_MSB:ENP_TABLE_LSB] == ENP_TABLE_EEE);
  for (genvar p = 0; p < ENP_NPORT; p++) begin : g_hit
    assign ind.port_hit[p] = table_ok &&
      (ctrl[ENP_PORT_MSB:ENP_PORT_LSB] == ENP_FIRST_PORT + 4'(p));
  end
  assign ind.offset = offset;
  assign ind.wr = reg_wr && (reg_addr == ENP_ADDR_IND_DATA);
  assign ind.wbyte = reg_wdata;

  // --------------------------------------------------------------
  // read data, registered one cycle after the strobe
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ENP_ADDR_IND_CTRL: reg_rdata <= ctrl;
        ENP_ADDR_IND_OFFSET: reg_rdata <= offset;
        ENP_ADDR_IND_DATA: reg_rdata <= ind.rd_byte;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : enp_indirect

// >>> enp_lp_model.sv
// link partner model: sends codeword bursts on either lane
`timescale 1ns/1ps
module enp_lp_model
  import enp_pkg::*;
(
  // clock
  input wire logic ref_clk,
  // bursts toward the bank
  output logic [ENP_NPORT-1:0] rx_valid,
  output logic [ENP_NPORT-1:0][15:0] rx_cw
);
  initial begin
    rx_valid = '0;
    rx_cw = '0;
  end
  // one burst, then gap idle cycles; idle shows the inverse so stale data never looks valid
  task automatic burst(input int p, input logic [15:0] cw, input int gap);
    @(posedge ref_clk);
    #1;
    rx_valid[p] = 1'b1;
    rx_cw[p] = cw;
    @(posedge ref_clk);
    #1;
    rx_valid[p] = 1'b0;
    rx_cw[p] = ~cw;
    repeat (gap) @(posedge ref_clk);
  endtask : burst
endmodule : enp_lp_model

// >>> enp_pkg.sv
// constants shared by the next-page register bank files
package enp_pkg;
  // direct byte registers of the management port
  localparam logic [7:0] ENP_ADDR_IND_CTRL = 8'h6E;
  localparam logic [7:0] ENP_ADDR_IND_OFFSET = 8'h6F;
  localparam logic [7:0] ENP_ADDR_IND_DATA = 8'hA0;
  // indirect control fields
  localparam int ENP_TABLE_MSB = 7;
  localparam int ENP_TABLE_LSB = 5;
  localparam logic [2:0] ENP_TABLE_EEE = 3'h1;
  localparam int ENP_PORT_MSB = 3;
  localparam int ENP_PORT_LSB = 0;
  localparam logic [3:0] ENP_FIRST_PORT = 4'h3;
  localparam int ENP_NPORT = 2;
  // indirect byte offsets, even offset holds the high byte
  localparam logic [7:0] ENP_OFF_TX_HI = 8'h0E;
  localparam logic [7:0] ENP_OFF_TX_LO = 8'h0F;
  localparam logic [7:0] ENP_OFF_LP_HI = 8'h10;
  localparam logic [7:0] ENP_OFF_LP_LO = 8'h11;
  localparam logic [7:0] ENP_OFF_CAP_HI = 8'h28;
  localparam logic [7:0] ENP_OFF_CAP_LO = 8'h29;
  // codeword bit positions
  localparam int ENP_BIT_MORE = 15;
  localparam int ENP_BIT_ACK = 14;
  localparam int ENP_BIT_MSG = 13;
  localparam int ENP_BIT_COMPLY = 12;
  localparam int ENP_BIT_TOGGLE = 11;
  localparam int ENP_CODE_MSB = 10;
  // reset values
  localparam logic [7:0] ENP_CTRL_RESET = 8'h00;
  localparam logic [7:0] ENP_OFFSET_RESET = 8'h00;
  localparam logic ENP_MORE_RESET = 1'b0;
  localparam logic ENP_MSG_RESET = 1'b1;
  localparam logic ENP_COMPLY_RESET = 1'b0;
  localparam logic [10:0] ENP_CODE_RESET = 11'h000;
  localparam logic [15:0] ENP_LP_RESET = 16'h0000;
  localparam logic [15:0] ENP_CAP_STATUS = 16'h0000;
  // consistent bursts needed before acknowledging
  localparam logic [1:0] ENP_MATCH_NEEDED = 2'h3;
endpackage : enp_pkg

// >>> test_enp_eee_np_regs.sv
// self-checking bench for the next-page register bank
`timescale 1ns/1ps
module test_enp_eee_np_regs;
  import enp_pkg::*;
  // ------------------------------------
  // stimulus, scoreboard and counters
  // ------------------------------------
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [ENP_NPORT-1:0] lnk_restart = '0;
  logic [ENP_NPORT-1:0] lnk_base_sent = '0;
  logic [ENP_NPORT-1:0] lnk_page_sent = '0;
  logic [ENP_NPORT-1:0][15:0] lnk_base_cw = '0;
  logic [ENP_NPORT-1:0] lnk_rx_valid;
  logic [ENP_NPORT-1:0] lnk_page_rx;
  logic [ENP_NPORT-1:0][15:0] lnk_rx_cw;
  logic [ENP_NPORT-1:0][15:0] lnk_tx_cw;
  logic [7:0] rq[$];
  logic [7:0] rm[$];
  logic [15:0] lq[$];
  logic [7:0] offs [6] = '{8'h0E, 8'h0F, 8'h10, 8'h11, 8'h28, 8'h29};
  logic [7:0] mv;
  logic [15:0] txw;
  logic [15:0] pg;
  logic tog;
  int bad_count = 0;
  int cmp_count = 0;
  enp_eee_np_regs enp_eee_np_regs_inst (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lnk_restart(lnk_restart), .lnk_base_sent(lnk_base_sent),
    .lnk_base_cw(lnk_base_cw), .lnk_page_sent(lnk_page_sent), .lnk_rx_valid(lnk_rx_valid),
    .lnk_rx_cw(lnk_rx_cw), .lnk_tx_cw(lnk_tx_cw), .lnk_page_rx(lnk_page_rx));
  enp_lp_model lp_inst (.ref_clk(ref_clk), .rx_valid(lnk_rx_valid), .rx_cw(lnk_rx_cw));
  // bench clock, 8 ns period
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // one register access; a read books its expected byte and mask first
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    if (!w) begin
      rq.push_back(d);
      rm.push_back(m);
    end
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask : acc
  // one-cycle lane event: 0 restart, 1 base sent, 2 page sent
  task automatic pulse(input int k, input int p);
    @(posedge ref_clk);
    #1;
    lnk_restart[p] = (k == 0);
    lnk_base_sent[p] = (k == 1);
    lnk_page_sent[p] = (k == 2);
    @(posedge ref_clk);
    #1;
    lnk_restart = '0;
    lnk_base_sent = '0;
    lnk_page_sent = '0;
  endtask : pulse
  // read result is sampled one edge after the strobe edge, once it has settled
  always @(posedge ref_clk) begin
    if (reg_rd === 1'b1) begin
      @(posedge ref_clk);
      #2;
      mv = rm.pop_front();
      chk(16'(reg_rdata & mv), 16'(rq.pop_front() & mv));
    end
  end
  // every settled partner page is met against the booked transmit word
  always @(posedge ref_clk) begin
    #2;
    for (int p = 0; p < ENP_NPORT; p++)
      if (lnk_page_rx[p] === 1'b1)
        chk(lnk_tx_cw[p], lq.pop_front());
  end
  initial begin
    #400000;
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(85068));
    repeat (2) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    acc(1'b1, ENP_ADDR_IND_CTRL, 8'h23, 8'h00);
    for (int i = 0; i < 6; i++) begin
      acc(1'b1, ENP_ADDR_IND_OFFSET, offs[i], 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, (i == 0) ? 8'h28 : 8'h00, 8'hBF);
    end
    acc(1'b0, 8'h55, 8'h00, 8'hFF);
    for (int p = 0; p < ENP_NPORT; p++) begin
      pulse(0, p);
      acc(1'b1, ENP_ADDR_IND_CTRL, 8'h23 + 8'(p), 8'h00);
      txw = 16'($urandom);
      acc(1'b1, ENP_ADDR_IND_OFFSET, ENP_OFF_TX_HI, 8'h00);
      acc(1'b1, ENP_ADDR_IND_DATA, txw[15:8], 8'h00);
      acc(1'b1, ENP_ADDR_IND_OFFSET, ENP_OFF_TX_LO, 8'h00);
      acc(1'b1, ENP_ADDR_IND_DATA, txw[7:0], 8'h00);
      txw = txw & 16'hB7FF;
      lnk_base_cw[p] = 16'($urandom);
      tog = ~lnk_base_cw[p][ENP_BIT_TOGGLE];
      pulse(1, p);
      acc(1'b1, ENP_ADDR_IND_OFFSET, ENP_OFF_TX_HI, 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, txw[15:8] | {4'h0, tog, 3'h0}, 8'hBF);
      pg = 16'($urandom);
      lq.push_back({txw[15], 1'b1, txw[13:12], tog, txw[10:0]});
      lp_inst.burst(p, pg ^ 16'h0100, 0);
      lp_inst.burst(p, pg ^ 16'h0100, 3);
      for (int i = 0; i < 3; i++)
        lp_inst.burst(p, pg ^ ((i == 1) ? 16'h4000 : 16'h0000), $urandom_range(5, 0));
      acc(1'b1, ENP_ADDR_IND_OFFSET, ENP_OFF_LP_HI, 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, pg[15:8], 8'hBF);
      acc(1'b1, ENP_ADDR_IND_OFFSET, ENP_OFF_LP_LO, 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, pg[7:0], 8'hFF);
      pulse(2, p);
      tog = ~tog;
      acc(1'b1, ENP_ADDR_IND_OFFSET, ENP_OFF_TX_HI, 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, txw[15:8] | {4'h0, tog, 3'h0}, 8'hBF);
      acc(1'b1, ENP_ADDR_IND_OFFSET, ENP_OFF_TX_LO, 8'h00);
      acc(1'b1, ENP_ADDR_IND_CTRL, 8'h43, 8'h00);
      acc(1'b1, ENP_ADDR_IND_DATA, 8'hFF, 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, 8'h00, 8'hFF);
      acc(1'b1, ENP_ADDR_IND_CTRL, 8'h25, 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, 8'h00, 8'hFF);
      acc(1'b1, ENP_ADDR_IND_CTRL, 8'h23 + 8'(p), 8'h00);
      acc(1'b0, ENP_ADDR_IND_DATA, txw[7:0], 8'hFF);
    end
    chk(16'(lq.size()), 16'h0000);
    report_and_stop();
  end
endmodule : test_enp_eee_np_regs
bind enp_eee_np_regs enp_checker enp_checker_inst (
  .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .lnk_restart(lnk_restart), .lnk_base_sent(lnk_base_sent),
  .lnk_base_cw(lnk_base_cw), .lnk_page_sent(lnk_page_sent), .lnk_rx_valid(lnk_rx_valid),
  .lnk_rx_cw(lnk_rx_cw), .lnk_tx_cw(lnk_tx_cw), .lnk_page_rx(lnk_page_rx));
